/* File: acc_core_model.sv */
// Behavioural converter core answering the start requests
`timescale 1ns/100ps
`default_nettype none
module acc_core_model (
	// Clock and reset
	input	wire logic		hclk,
	input	wire logic		hresetn,
	// Control side
	input	wire logic		start_regular,
	input	wire logic		start_injected,
	input	wire logic		scan_enable,
	input	wire logic [4:0]	chan,
	input	wire logic		oow,
	// Core outputs
	output	var logic		core_reg_started,
	output	var logic		core_inj_started,
	output	var logic		core_chan_done,
	output	var logic [4:0]	core_chan,
	output	var logic		core_chan_injected,
	output	var logic		core_last_in_seq,
	output	var logic		core_out_of_window
);
	logic [2:0] cnt;
	logic inj;
	// Idle tail of three cycles lets the start bits drop before relaunch
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{core_reg_started, core_inj_started, core_chan_done, inj} <= 4'h0;
			{core_chan, core_chan_injected, core_last_in_seq, core_out_of_window} <= 8'h0;
			cnt <= 3'h0;
		end else begin
			core_reg_started <= 1'b0;
			core_inj_started <= 1'b0;
			core_chan_done <= 1'b0;
			// Qualifiers toggle when not valid
			core_chan <= ~core_chan;
			core_chan_injected <= ~core_chan_injected;
			core_last_in_seq <= ~core_last_in_seq;
			core_out_of_window <= ~core_out_of_window;
			if (cnt > 3'h3) begin
				core_chan_done <= 1'b1;
				core_chan <= chan;
				core_chan_injected <= inj;
				core_last_in_seq <= cnt == 3'h4;
				core_out_of_window <= oow;
				cnt <= cnt - 3'h1;
			end else if (cnt != 3'h0) begin
				cnt <= cnt - 3'h1;
			end else if (start_injected || start_regular) begin
				inj <= start_injected;
				core_inj_started <= start_injected;
				core_reg_started <= !start_injected;
				cnt <= scan_enable ? 3'h6 : 3'h4;
			end
		end
	end
endmodule
`default_nettype wire

/* File: acc_ctrl.v */
// Converter control registers with AHB-Lite slave and interrupt logic
//
// How it works
// [R1] Bit 11 enables regular discontinuous conversion
// [R2] Bit 10 queues injected group after regular
// [R3] Bit 9 restricts watchdog to one channel
// [R4] Bit 8 enables scanning of sequence lists
// [R5] Scan mode: flag only after last channel
// [R6] Bit 7 enables injected-done interrupt
// [R7] Bit 6 enables watchdog interrupt
// [R8] Bit 5 enables conversion-done interrupt
// [R9] Bits 4:0 select guarded channel 0..17
// [R10] Control two bits 31:24 read zero
// [R11] Enable bit connects temperature/reference channel
// [R12] Regular start needs software trigger; self-clears
// [R13] Injected start cleared by software or hardware
// [R14] Discontinuous count 000..111 means 1..8
// [R15] Conversion-done flag set on group end
// [R16] Injected-done flag set after whole group
// [R17] Watchdog flag set on out-of-window value
// [R18] One interrupt while enabled flag set
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "acc_map.vh"
module acc_ctrl #(
	parameter NCH = 18
) (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Converter core side
	input  wire        core_reg_started,
	input  wire        core_inj_started,
	input  wire        core_chan_done,
	input  wire [4:0]  core_chan,
	input  wire        core_chan_injected,
	input  wire        core_last_in_seq,
	input  wire        core_out_of_window,
	output reg         start_regular,
	output reg         start_injected,
	output reg         scan_enable,
	output reg         regular_discontinuous_enable,
	output reg  [3:0]  discontinuous_channels,
	output reg         temp_ref_channel_enable,
	// Interrupt
	output reg         irq
);

	////////////////////////////////////////////////////////////////////
	// Registers
	reg [31:0] ctrl_one_reg;
	reg [31:0] ctrl_two_reg;
	reg [31:0] irq_mask_reg;
	reg        auto_inj_pend_reg;
	reg        ap_valid_reg;
	reg        ap_write_reg;
	reg [7:0]  ap_addr_reg;

	wire [`ACC_EV_W-1:0] flag_reg;
	wire [`ACC_EV_W-1:0] irq_stat_reg;

	function is_addr;
		input [7:0] a;
		input [7:0] b;
		begin
			is_addr = (a == b);
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Bus address phase capture
	wire ap_take = hsel & hready & (htrans == `ACC_HTRANS_NONSEQ);
	wire wr_dp   = ap_valid_reg & ap_write_reg;
	wire rd_ap   = ap_take & ~hwrite;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid_reg <= 1'b0;
			ap_write_reg <= 1'b0;
			ap_addr_reg  <= 8'h00;
		end else begin
			ap_valid_reg <= ap_take;
			ap_write_reg <= hwrite;
			ap_addr_reg  <= haddr;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Field views
	wire wd_single = ctrl_one_reg[`ACC_C1_WDSGL];
	wire [4:0] wd_chan = ctrl_one_reg[`ACC_C1_WDCH_MSB:`ACC_C1_WDCH_LSB];
	wire sw_trig = (ctrl_two_reg[`ACC_C2_TRIG_MSB:`ACC_C2_TRIG_LSB] == `ACC_TRIG_SOFTWARE);
	wire wr_c1 = wr_dp & is_addr(ap_addr_reg, `ACC_OFF_CTRL_ONE);
	wire wr_c2 = wr_dp & is_addr(ap_addr_reg, `ACC_OFF_CTRL_TWO);

	////////////////////////////////////////////////////////////////////
	// Event detection
	// Group end: only last channel counts when scanning
	wire grp_end = core_chan_done &
		(~ctrl_one_reg[`ACC_C1_SCAN] | core_last_in_seq);  // [R5]
	wire reg_grp_end = grp_end & ~core_chan_injected;
	wire inj_grp_end = grp_end & core_chan_injected;        // [R16]
	// Reserved channel codes never match, so no false event
	wire wd_guarded = ~wd_single |
		((core_chan == wd_chan) & (wd_chan <= `ACC_WDCH_MAX));  // [R3] [R9]
	wire wd_hit = core_chan_done & core_out_of_window & wd_guarded;  // [R17]

	wire [`ACC_EV_W-1:0] ev_set;
	assign ev_set[`ACC_EV_EOC]  = grp_end;                  // [R15]
	assign ev_set[`ACC_EV_INJECTED_DONE_FLAG] = inj_grp_end;              // [R16]
	assign ev_set[`ACC_EV_WD]   = wd_hit;                   // [R17]

	// Status flags: software clears by writing zero
	wire [`ACC_EV_W-1:0] flag_clr = (wr_dp & is_addr(ap_addr_reg, `ACC_OFF_STATUS)) ?
		~hwdata[`ACC_EV_W-1:0] : {`ACC_EV_W{1'b0}};

	acc_evt_flag #(.W(`ACC_EV_W)) u_flags (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.set_i    (ev_set),
		.clr_i    (flag_clr),
		.flag_reg (flag_reg)
	);

	// Interrupt status: cleared by reading it
	wire [`ACC_EV_W-1:0] istat_clr = (rd_ap & is_addr(haddr, `ACC_OFF_IRQ_STATUS)) ?
		{`ACC_EV_W{1'b1}} : {`ACC_EV_W{1'b0}};

	acc_evt_flag #(.W(`ACC_EV_W)) u_istat (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.set_i    (ev_set),
		.clr_i    (istat_clr),
		.flag_reg (irq_stat_reg)
	);

	////////////////////////////////////////////////////////////////////
	// Control register writes
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_one_reg <= `ACC_RESET_WORD;
			irq_mask_reg <= `ACC_RESET_WORD;
		end else begin
			if (wr_c1)
				ctrl_one_reg <= hwdata & `ACC_C1_WMASK;  // [R1] [R2] [R4] [R9] [R14]
			if (wr_dp & is_addr(ap_addr_reg, `ACC_OFF_IRQ_MASK))
				irq_mask_reg <= {{(32-`ACC_EV_W){1'b0}}, hwdata[`ACC_EV_W-1:0]};
		end
	end

	// Start bits: hardware clear loses to a same-cycle write of one
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_two_reg <= `ACC_RESET_WORD;
		end else begin
			if (wr_c2)
				ctrl_two_reg <= hwdata & `ACC_C2_WMASK;  // [R10] [R11]
			else begin
				if (core_reg_started)
					ctrl_two_reg[`ACC_C2_REGULAR_SOFTWARE_START] <= 1'b0;  // [R12]
				if (core_inj_started)
					ctrl_two_reg[`ACC_C2_INJECTED_SOFTWARE_START] <= 1'b0;  // [R13]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Automatic injected group after regular group
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			auto_inj_pend_reg <= 1'b0;
		else if (reg_grp_end & ctrl_one_reg[`ACC_C1_AUTO_INJECTED_AFTER_REGULAR])
			auto_inj_pend_reg <= 1'b1;  // [R2]
		else if (core_inj_started)
			auto_inj_pend_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Core-facing outputs, all registered
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_regular                <= 1'b0;
			start_injected               <= 1'b0;
			scan_enable                  <= 1'b0;
			regular_discontinuous_enable <= 1'b0;
			discontinuous_channels       <= `ACC_DCNT_BASE;
			temp_ref_channel_enable      <= 1'b0;
		end else begin
			start_regular  <= ctrl_two_reg[`ACC_C2_REGULAR_SOFTWARE_START] & sw_trig & ~core_reg_started;  // [R12]
			start_injected <= (ctrl_two_reg[`ACC_C2_INJECTED_SOFTWARE_START] | auto_inj_pend_reg) &
				~core_inj_started;  // [R13] [R2]
			scan_enable    <= ctrl_one_reg[`ACC_C1_SCAN];  // [R4]
			regular_discontinuous_enable <= ctrl_one_reg[`ACC_C1_DISC];  // [R1]
			discontinuous_channels <= {1'b0,
				ctrl_one_reg[`ACC_C1_DNUM_MSB:`ACC_C1_DNUM_LSB]} + `ACC_DCNT_BASE;  // [R14]
			temp_ref_channel_enable <= ctrl_two_reg[`ACC_C2_TSREF];  // [R11]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt output
	// Enable bits gate flags; mask register gates sticky status
	wire irq_en_hit =
		(flag_reg[`ACC_EV_EOC]  & ctrl_one_reg[`ACC_C1_CONVERSION_DONE_IRQ_ENABLE]) |    // [R8]
		(flag_reg[`ACC_EV_INJECTED_DONE_FLAG] & ctrl_one_reg[`ACC_C1_INJECTED_DONE_IRQ_ENABLE]) |   // [R6]
		(flag_reg[`ACC_EV_WD]   & ctrl_one_reg[`ACC_C1_WATCHDOG_IRQ_ENABLE]);     // [R7]
	wire irq_st_hit = |(irq_stat_reg & irq_mask_reg[`ACC_EV_W-1:0]);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= irq_en_hit | irq_st_hit;  // [R18]
	end

	////////////////////////////////////////////////////////////////////
	// Read data, one-cycle data phase, zero wait states
	reg [31:0] rd_next;
	always @* begin
		case (haddr)
			`ACC_OFF_STATUS:     rd_next = {{(32-`ACC_EV_W){1'b0}}, flag_reg};
			`ACC_OFF_CTRL_ONE:   rd_next = ctrl_one_reg;
			`ACC_OFF_CTRL_TWO:   rd_next = ctrl_two_reg;  // [R10]
			`ACC_OFF_IRQ_STATUS: rd_next = {{(32-`ACC_EV_W){1'b0}}, irq_stat_reg};
			`ACC_OFF_IRQ_MASK:   rd_next = irq_mask_reg;
			default:             rd_next = `ACC_RESET_WORD;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= `ACC_RESET_WORD;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (rd_ap)
				hrdata <= rd_next;
		end
	end

endmodule
`default_nettype wire

/* File: acc_ctrl_assertions.sv */
// Concurrent checks on the converter control block ports
`timescale 1ns/100ps
`default_nettype none
module acc_ctrl_assertions (
	// Bus
	input	wire logic		hclk,
	input	wire logic		hresetn,
	input	wire logic		hsel,
	input	wire logic [7:0]	haddr,
	input	wire logic [1:0]	htrans,
	input	wire logic		hwrite,
	input	wire logic		hready,
	input	wire logic		hreadyout,
	input	wire logic		hresp,
	// Core side and outputs
	input	wire logic		core_reg_started,
	input	wire logic		core_inj_started,
	input	wire logic		core_chan_done,
	input	wire logic		start_regular,
	input	wire logic		start_injected,
	input	wire logic		scan_enable,
	input	wire logic		regular_discontinuous_enable,
	input	wire logic [3:0]	discontinuous_channels,
	input	wire logic		temp_ref_channel_enable,
	input	wire logic		irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire wr = hsel && hready && hwrite && htrans == 2'h2;
	wire w1 = wr && haddr == 8'h04;
	wire w2 = wr && haddr == 8'h08;
	////////////////
	property p_okay; hreadyout && !hresp; endproperty
	a_okay: assert property (p_okay) else $error("bus stall or error");
	property p_rs_src; $rose(start_regular) |-> $past(w2, 3); endproperty
	a_rs_src: assert property (p_rs_src) else $error("regular start unasked");
	property p_rs_clr; core_reg_started |-> ##3 !start_regular; endproperty
	a_rs_clr: assert property (p_rs_clr) else $error("regular start kept");
	property p_ri_clr; core_inj_started |-> ##3 !start_injected; endproperty
	a_ri_clr: assert property (p_ri_clr) else $error("injected start kept");
	property p_scan; $changed(scan_enable) |-> $past(w1, 3); endproperty
	a_scan: assert property (p_scan) else $error("scan changed alone");
	property p_disc; $changed(regular_discontinuous_enable) |-> $past(w1, 3); endproperty
	a_disc: assert property (p_disc) else $error("disc changed alone");
	property p_cnt; $changed(discontinuous_channels) |-> $past(w1, 3); endproperty
	a_cnt: assert property (p_cnt) else $error("count changed alone");
	property p_temp; $changed(temp_ref_channel_enable) |-> $past(w2, 3); endproperty
	a_temp: assert property (p_temp) else $error("temp enable changed alone");
	property p_irq; $rose(irq) |-> $past(core_chan_done, 2) || $past(wr, 3); endproperty
	a_irq: assert property (p_irq) else $error("irq without cause");
	c_reg: cover property (core_reg_started);
	c_inj: cover property (core_inj_started);
	c_irq: cover property ($fell(irq));
endmodule
bind acc_ctrl acc_ctrl_assertions i_acc_ctrl_assertions (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hreadyout, .hresp, .core_reg_started, .core_inj_started,
	.core_chan_done, .start_regular, .start_injected, .scan_enable,
	.regular_discontinuous_enable, .discontinuous_channels, .temp_ref_channel_enable, .irq);
`default_nettype wire

/* File: acc_evt_flag.v */
// Sticky event flag, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module acc_evt_flag #(
	parameter W = 3
) (
	// Clock and reset
	input  wire         hclk,
	input  wire         hresetn,
	// Events and clears
	input  wire [W-1:0] set_i,
	input  wire [W-1:0] clr_i,
	// Flags
	output reg  [W-1:0] flag_reg
);

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_flag
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					flag_reg[i] <= 1'b0;
				else if (set_i[i])
					flag_reg[i] <= 1'b1;
				else if (clr_i[i])
					flag_reg[i] <= 1'b0;
			end
		end
	endgenerate

endmodule
`default_nettype wire

/* File: acc_map.vh */
// Register map, field positions and codes of the converter control block
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

// Byte offsets
`define ACC_OFF_STATUS      8'h00
`define ACC_OFF_CTRL_ONE    8'h04
`define ACC_OFF_CTRL_TWO    8'h08
`define ACC_OFF_IRQ_STATUS  8'h0c
`define ACC_OFF_IRQ_MASK    8'h10

// Control one fields
`define ACC_C1_WDCH_LSB     0
`define ACC_C1_WDCH_MSB     4
`define ACC_C1_CONVERSION_DONE_IRQ_ENABLE        5
`define ACC_C1_WATCHDOG_IRQ_ENABLE        6
`define ACC_C1_INJECTED_DONE_IRQ_ENABLE       7
`define ACC_C1_SCAN         8
`define ACC_C1_WDSGL        9
`define ACC_C1_AUTO_INJECTED_AFTER_REGULAR        10
`define ACC_C1_DISC         11
`define ACC_C1_DNUM_LSB     13
`define ACC_C1_DNUM_MSB     15
`define ACC_C1_WMASK        32'h0000efff
// Count code zero means one channel, so the output is code plus one
`define ACC_DCNT_BASE       4'h1

// Control two fields
`define ACC_C2_TSREF        23
`define ACC_C2_REGULAR_SOFTWARE_START      22
`define ACC_C2_INJECTED_SOFTWARE_START     21
`define ACC_C2_TRIG_LSB     17
`define ACC_C2_TRIG_MSB     19
`define ACC_C2_WMASK        32'h00ee0000
`define ACC_TRIG_SOFTWARE   3'h7

// Status / event bit positions
`define ACC_EV_WD           0
`define ACC_EV_EOC          1
`define ACC_EV_INJECTED_DONE_FLAG         2
`define ACC_EV_W            3

// Highest legal watchdog channel code
`define ACC_WDCH_MAX        5'h11

`define ACC_RESET_WORD      32'h00000000
`define ACC_HTRANS_NONSEQ   2'h2

`endif

/* File: test_adc_conversion_control_regs.sv */
// Register-level test of the converter control block
`timescale 1ns/100ps
`default_nettype none
module test_adc_conversion_control_regs;
	logic hclk, hresetn, hsel, hwrite, oow;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, rd, v;
	logic [4:0] chan;
	wire [31:0] hrdata;
	wire hreadyout, hresp, irq, core_reg_started, core_inj_started, core_chan_done;
	wire core_chan_injected, core_last_in_seq, core_out_of_window, start_regular;
	wire start_injected, scan_enable, regular_discontinuous_enable, temp_ref_channel_enable;
	wire [4:0] core_chan;
	wire [3:0] discontinuous_channels;
	integer n_errors, total_checks, i;
	acc_ctrl i_acc_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .core_reg_started, .core_inj_started,
		.core_chan_done, .core_chan, .core_chan_injected, .core_last_in_seq,
		.core_out_of_window, .start_regular, .start_injected, .scan_enable,
		.regular_discontinuous_enable, .discontinuous_channels, .temp_ref_channel_enable, .irq);
	acc_core_model i_acc_core_model (.hclk, .hresetn, .start_regular, .start_injected,
		.scan_enable, .chan, .oow, .core_reg_started, .core_inj_started, .core_chan_done,
		.core_chan, .core_chan_injected, .core_last_in_seq, .core_out_of_window);
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	////////////////
	task results;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e, input string n);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// Bounded wait for the slave ready
	task step;
		integer k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1) begin
			n_errors++;
			results;
		end
	endtask
	task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		step;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		step;
		rd = hrdata;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		xf(1'b0, a, 32'h0);
		chk(rd, e, $sformatf("reg %h", a));
	endtask
	// Polls until the value shows or the bound runs out
	task pl(input logic [7:0] a, input logic [31:0] e);
		integer k;
		rd = ~e;
		for (k = 0; k < 40 && rd !== e; k++) xf(1'b0, a, 32'h0);
		chk(rd, e, $sformatf("poll %h", a));
		if (rd !== e) results;
	endtask
	task wirq(input logic e);
		integer k;
		for (k = 0; k < 200 && irq !== e; k++) @(posedge hclk);
		chk({31'h0, irq}, {31'h0, e}, "irq");
		if (irq !== e) results;
	endtask
	////////////////
	initial begin
		{hresetn, hsel, hwrite, haddr, htrans, hwdata, chan, oow} = '0;
		hsize = 3'h2;
		n_errors = 0;
		total_checks = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		for (i = 0; i < 6; i++) rc(i * 4, 32'h0);
		xf(1'b1, 8'h14, 32'hffffffff);
		rc(8'h14, 32'h0);
		chk(discontinuous_channels, 4'h1, "count");
		$display("reset test done");
		for (i = 0; i < 18; i++) begin
			v = 32'h0b00 + (i % 8) * 8192 + i;
			xf(1'b1, 8'h04, v);
			rc(8'h04, v);
			chk(discontinuous_channels, i % 8 + 1, "count");
			chk({scan_enable, regular_discontinuous_enable}, 2'h3, "modes");
		end
		xf(1'b1, 8'h04, 32'hffffffff);
		rc(8'h04, 32'h0000efff);
		xf(1'b1, 8'h08, 32'hff800000);
		rc(8'h08, 32'h00800000);
		chk(temp_ref_channel_enable, 1'b1, "temp");
		xf(1'b1, 8'h04, 32'h0);
		xf(1'b1, 8'h08, 32'h00400000);
		rc(8'h00, 32'h0);
		chk(start_regular, 1'b0, "start");
		$display("field test done");
		xf(1'b1, 8'h04, 32'h20);
		xf(1'b1, 8'h08, 32'h004e0000);
		wirq(1'b1);
		rc(8'h08, 32'h000e0000);
		rc(8'h00, 32'h2);
		rc(8'h0c, 32'h2);
		rc(8'h0c, 32'h0);
		xf(1'b1, 8'h00, 32'h0);
		wirq(1'b0);
		xf(1'b1, 8'h08, 32'h002e0000);
		pl(8'h00, 32'h6);
		rc(8'h08, 32'h000e0000);
		xf(1'b1, 8'h00, 32'h0);
		$display("start test done");
		// Reset in mid-run must drop every mode output again
		xf(1'b1, 8'h04, 32'h0000efff);
		repeat (2) @(posedge hclk);
		chk(scan_enable, 1'b1, "scan");
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rc(8'h04, 32'h0);
		chk({irq, scan_enable, regular_discontinuous_enable, discontinuous_channels}, 7'h01,
			"reset outs");
		$display("second reset test done");
		// Channel 3 guarded alone, 4 outside it, 5 with all channels guarded
		for (i = 3; i < 6; i++) begin
			chan <= i;
			oow <= 1'b1;
			xf(1'b1, 8'h0c, 32'h0);
			xf(1'b1, 8'h04, i == 5 ? 32'h5c3 : 32'h7c3);
			xf(1'b1, 8'h08, 32'h004e0000);
			wirq(1'b1);
			pl(8'h00, i == 4 ? 32'h6 : 32'h7);
			xf(1'b1, 8'h04, 32'h0);
			wirq(1'b0);
			xf(1'b1, 8'h10, 32'h4);
			wirq(1'b1);
			rc(8'h0c, i == 4 ? 32'h6 : 32'h7);
			wirq(1'b0);
			xf(1'b1, 8'h10, 32'h0);
			xf(1'b1, 8'h00, 32'h0);
		end
		$display("scan test done");
		results;
	end
endmodule
`default_nettype wire
